// ===== src/rcf_pkg.sv
// Constants and types for the reset-cause flag block
package rcf_pkg;
    // Bus geometry
    localparam int ADDR_W = 5;
    localparam int DATA_W = 32;
    localparam int STRB_W = 4;
    localparam int FLAG_W = 8;
    localparam int SYNC_N = 3;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFF_FLAGS = 5'h00;
    localparam logic [ADDR_W-1:0] OFF_STAT = 5'h04;
    localparam logic [ADDR_W-1:0] OFF_MASK = 5'h08;
    localparam logic [ADDR_W-1:0] OFF_ENAB = 5'h0C;

    // Bit positions in the flag register
    localparam int BIT_PIN = 0;
    localparam int BIT_PWR = 1;
    localparam int BIT_CLK = 2;
    localparam int BIT_WDT = 3;
    localparam int BIT_SOFT = 4;
    localparam int BIT_CMP = 5;
    localparam int N_CAUSE = 6;

    // Reset values and field masks
    localparam logic [FLAG_W-1:0] FLAGS_POR = 8'h02;
    localparam logic [FLAG_W-1:0] ENAB_POR = 8'h00;
    localparam logic [FLAG_W-1:0] ENAB_MASK = 8'h26;
    localparam logic [FLAG_W-1:0] CAUSE_MASK = 8'h3F;
    localparam logic [FLAG_W-1:0] ZERO8 = 8'h00;
    localparam logic [SYNC_N-1:0] SYNC_IDLE = 3'h5;

    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic {RCF_RUN, RCF_HOLD} rcf_state_e;
    typedef enum logic [2:0] {SEL_FLAGS, SEL_STAT, SEL_MASK, SEL_ENAB, SEL_NONE} rcf_sel_e;
endpackage : rcf_pkg

// ===== src/rcf_reset_cause_flags.sv
// Reset-cause flags, reset-source enables and reset combiner with AXI4-Lite access
//
// Contract
// - bit 2 write one arms clock-loss detector
// - bit 2 reads one after clock-loss reset
// - bit 1 write one arms supply monitor
// - bit 1 set on power-on/supply reset
// - watchdog flag shows cause, ignores writes
// - bit 4 reads one after software reset
// - bit 5 arms comparator; flags its reset
// - pin flag shows pin reset, read-only
// - bit 4 write one forces reset now
// - bit 7 ignores writes, reads zero
//
// Local design decisions: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ns
module rcf_reset_cause_flags (
    // Clock and power-on reset
    input wire logic core_clk,
    input wire logic srst,
    // AXI4-Lite write address and data
    input wire logic [rcf_pkg::ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [rcf_pkg::DATA_W-1:0] wdata,
    input wire logic [rcf_pkg::STRB_W-1:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // AXI4-Lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read
    input wire logic [rcf_pkg::ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [rcf_pkg::DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Reset requests from detectors and pins
    input wire logic supplyTrip,
    input wire logic clkLossReq,
    input wire logic wdtReq,
    input wire logic cmp0Out,
    input wire logic rstPinN,
    // Outputs to the system
    output logic sysRst,
    output logic clkLossEnable,
    output logic irq
);
    import rcf_pkg::*;

    function automatic rcf_sel_e decodeSel(input logic [ADDR_W-1:0] a);
        case ({a[ADDR_W-1:2], 2'h0})
            OFF_FLAGS: decodeSel = SEL_FLAGS;
            OFF_STAT: decodeSel = SEL_STAT;
            OFF_MASK: decodeSel = SEL_MASK;
            OFF_ENAB: decodeSel = SEL_ENAB;
            default: decodeSel = SEL_NONE;
        endcase
    endfunction : decodeSel

    // Fixed priority when several sources fire together
    function automatic logic [FLAG_W-1:0] firstCause(input logic [N_CAUSE-1:0] r);
        logic [FLAG_W-1:0] c;
        c = ZERO8;
        if (r[BIT_PWR]) begin
            c[BIT_PWR] = 1'b1;
        end else if (r[BIT_CLK]) begin
            c[BIT_CLK] = 1'b1;
        end else if (r[BIT_WDT]) begin
            c[BIT_WDT] = 1'b1;
        end else if (r[BIT_SOFT]) begin
            c[BIT_SOFT] = 1'b1;
        end else if (r[BIT_CMP]) begin
            c[BIT_CMP] = 1'b1;
        end else if (r[BIT_PIN]) begin
            c[BIT_PIN] = 1'b1;
        end
        firstCause = c;
    endfunction : firstCause

    // Write channel state
    logic awHeld;
    logic wHeld;
    logic [ADDR_W-1:0] wAddr;
    logic [DATA_W-1:0] wData;
    logic [STRB_W-1:0] wStrb;
    rcf_sel_e wSel;
    rcf_sel_e rSel;
    logic doWrite;
    logic lane0;
    logic flagWr;
    logic statWr;
    logic maskWr;

    // Block state
    rcf_state_e state;
    rcf_state_e next_state;
    logic [FLAG_W-1:0] flags;
    logic [FLAG_W-1:0] enab;
    logic [FLAG_W-1:0] pending;
    logic [FLAG_W-1:0] stat;
    logic [FLAG_W-1:0] mask;
    logic [FLAG_W-1:0] next_stat;
    logic [FLAG_W-1:0] statClr;
    logic [FLAG_W-1:0] statSet;
    logic [DATA_W-1:0] readWord;
    logic [SYNC_N-1:0] syncA;
    logic [SYNC_N-1:0] syncB;
    logic [N_CAUSE-1:0] reqVec;
    logic swReq;
    logic anyReq;
    logic enterHold;
    logic leaveHold;

    // Write decode
    assign awready = !awHeld && !bvalid;
    assign wready = !wHeld && !bvalid;
    assign doWrite = awHeld && wHeld && !bvalid;
    assign wSel = decodeSel(wAddr);
    assign rSel = decodeSel(araddr);
    // Registers are 8 bits wide, so only the low lane counts
    assign lane0 = doWrite && wStrb[0];
    assign flagWr = lane0 && (wSel == SEL_FLAGS);
    assign statWr = lane0 && (wSel == SEL_STAT);
    assign maskWr = lane0 && (wSel == SEL_MASK);

    always_ff @(posedge core_clk) begin
        if (srst) begin
            awHeld <= 1'b0;
            wAddr <= OFF_FLAGS;
        end else if (awvalid && awready) begin
            awHeld <= 1'b1;
            wAddr <= awaddr;
        end else if (doWrite) begin
            awHeld <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            wHeld <= 1'b0;
            wData <= '0;
            wStrb <= '0;
        end else if (wvalid && wready) begin
            wHeld <= 1'b1;
            wData <= wdata;
            wStrb <= wstrb;
        end else if (doWrite) begin
            wHeld <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end else if (doWrite) begin
            bvalid <= 1'b1;
            bresp <= (wSel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // Read path; the cause register shows flags, never enables
    // bit seven zero
    assign readWord = (rSel == SEL_FLAGS) ? {24'h000000, flags & CAUSE_MASK} :
                      (rSel == SEL_STAT) ? {24'h000000, stat} :
                      (rSel == SEL_MASK) ? {24'h000000, mask} :
                      (rSel == SEL_ENAB) ? {24'h000000, enab} : 32'h00000000;
    assign arready = !rvalid;

    always_ff @(posedge core_clk) begin
        if (srst) begin
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata <= readWord;
            rresp <= (rSel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    // Pin, comparator and supply levels come from outside the clock
    always_ff @(posedge core_clk) begin
        if (srst) begin
            syncA <= SYNC_IDLE;
            syncB <= SYNC_IDLE;
        end else begin
            syncA <= {rstPinN, supplyTrip, cmp0Out};
            syncB <= syncA;
        end
    end

    assign swReq = flagWr && wData[BIT_SOFT];
    assign reqVec[BIT_PIN] = !syncB[2];
    assign reqVec[BIT_PWR] = enab[BIT_PWR] && syncB[1];
    assign reqVec[BIT_CLK] = enab[BIT_CLK] && clkLossReq;
    assign reqVec[BIT_WDT] = wdtReq;
    assign reqVec[BIT_SOFT] = swReq;
    assign reqVec[BIT_CMP] = enab[BIT_CMP] && !syncB[0];
    assign anyReq = |reqVec;
    assign enterHold = (state == RCF_RUN) && anyReq;
    assign leaveHold = (state == RCF_HOLD) && !anyReq;

    always_comb begin
        case (state)
            RCF_RUN: next_state = anyReq ? RCF_HOLD : RCF_RUN;
            RCF_HOLD: next_state = anyReq ? RCF_HOLD : RCF_RUN;
            default: next_state = RCF_RUN;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            state <= RCF_RUN;
            sysRst <= 1'b0;
        end else begin
            state <= next_state;
            sysRst <= (next_state == RCF_HOLD);
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            pending <= ZERO8;
            flags <= FLAGS_POR;
        end else if (enterHold) begin
            pending <= firstCause(reqVec);
        end else if (leaveHold) begin
            flags <= pending;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            enab <= ENAB_POR;
        end else if (flagWr) begin
            enab <= wData[FLAG_W-1:0] & ENAB_MASK;
        end
    end
    assign clkLossEnable = enab[BIT_CLK];

    // Sticky cause events; a set in the clear cycle wins
    assign statClr = statWr ? wData[FLAG_W-1:0] : ZERO8;
    assign statSet = leaveHold ? pending : ZERO8;
    assign next_stat = ((stat & ~statClr) | statSet) & CAUSE_MASK;

    always_ff @(posedge core_clk) begin
        if (srst) begin
            stat <= ZERO8;
            mask <= ZERO8;
            irq <= 1'b0;
        end else begin
            stat <= next_stat;
            irq <= |(next_stat & (maskWr ? wData[FLAG_W-1:0] : mask));
            if (maskWr) begin
                mask <= wData[FLAG_W-1:0] & CAUSE_MASK;
            end
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    chk_clk_arm: assert property (
        flagWr && wData[BIT_CLK] |=> clkLossEnable && enab[BIT_CLK])
        else $error("clock-loss enable not armed by write");

    chk_clk_flag: assert property (
        $fell(sysRst) && $past(pending[BIT_CLK]) |-> flags == 8'h04)
        else $error("clock-loss cause not latched alone");

    chk_supply_arm: assert property (
        (state == RCF_RUN) && enab[BIT_PWR] && syncB[1] |=> sysRst && pending[BIT_PWR])
        else $error("supply trip did not force reset");

    chk_pwr_flag: assert property (
        $fell(sysRst) && $past(pending[BIT_PWR]) |-> flags == FLAGS_POR)
        else $error("power flag not set alone");

    chk_flag_hold: assert property (
        (state == RCF_RUN) |=> $stable(flags))
        else $error("cause flags changed outside reset release");

    chk_soft_flag: assert property (
        $fell(sysRst) && $past(pending[BIT_SOFT]) |-> flags[BIT_SOFT] && $onehot(flags))
        else $error("software cause not latched");

    chk_cmp_reset: assert property (
        (state == RCF_RUN) && enab[BIT_CMP] && !syncB[0] |=> sysRst ##0 $onehot(pending))
        else $error("comparator low did not force reset");

    chk_pin_reset: assert property (
        (state == RCF_RUN) && !syncB[2] |=> sysRst)
        else $error("pin reset ignored");

    chk_soft_force: assert property (
        flagWr && wData[BIT_SOFT] && (state == RCF_RUN) |=> sysRst ##1 !sysRst || anyReq)
        else $error("software write did not force reset");

    chk_top_zero: assert property (
        rvalid && $rose(rvalid) |-> rdata[31:6] == 26'h0000000)
        else $error("unused bits read nonzero");

    chk_enab_keep: assert property (
        sysRst && !flagWr |=> $stable(enab))
        else $error("enable changed by system reset");

    chk_rst_merge: assert property (
        enterHold |=> sysRst && $onehot(pending))
        else $error("reset not asserted for a request");

endmodule : rcf_reset_cause_flags

// ===== test/rcf_reset_cause_flags_test.sv
// Self-checking bench for the reset-cause flag block over its register bus
`timescale 1ns/1ns
module rcf_reset_cause_flags_test;
    import rcf_pkg::*;
    logic core_clk = 1'h0;
    logic srst = 1'h1;
    logic [ADDR_W-1:0] awaddr = 5'h00;
    logic [ADDR_W-1:0] araddr = 5'h00;
    logic [DATA_W-1:0] wdata = 32'h0;
    logic [DATA_W-1:0] rdata;
    logic [STRB_W-1:0] wstrb = 4'h0;
    logic awvalid = 1'h0;
    logic wvalid = 1'h0;
    logic bready = 1'h0;
    logic arvalid = 1'h0;
    logic rready = 1'h0;
    logic awready, wready, bvalid, arready, rvalid, sysRst, clkLossEnable, irq;
    logic [1:0] bresp, rresp;
    logic supplyTrip = 1'h0;
    logic clkLossReq = 1'h0;
    logic wdtReq = 1'h0;
    logic cmp0Out = 1'h1;
    logic rstPinN = 1'h1;
    logic prevRst = 1'h0;
    int fail_count = 0;
    int n_checks = 0;
    int nRst = 0;

    rcf_reset_cause_flags u_dut (
        .core_clk(core_clk), .srst(srst),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .supplyTrip(supplyTrip), .clkLossReq(clkLossReq), .wdtReq(wdtReq),
        .cmp0Out(cmp0Out), .rstPinN(rstPinN),
        .sysRst(sysRst), .clkLossEnable(clkLossEnable), .irq(irq)
    );

    always #5 core_clk = ~core_clk;

    // Counts system reset episodes, so a merged or doubled reset shows up
    always @(posedge core_clk) begin
        if (sysRst === 1'h1 && prevRst !== 1'h1) begin
            nRst++;
        end
        prevRst <= sysRst;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t got %0h expected %0h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d, input logic [1:0] er);
        logic done;
        done = 1'h0;
        @(posedge core_clk);
        awaddr <= a;
        wdata <= {24'h0, d};
        wstrb <= 4'hF;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        while (!done) begin
            @(posedge core_clk);
            if (awready === 1'h1) begin
                awvalid <= 1'h0;
            end
            if (wready === 1'h1) begin
                wvalid <= 1'h0;
            end
            if (bvalid === 1'h1) begin
                chk({30'h0, bresp}, {30'h0, er});
                bready <= 1'h0;
                done = 1'h1;
            end
        end
    endtask : wr

    task automatic rc(input logic [ADDR_W-1:0] a, input logic [7:0] e, input logic [1:0] er);
        @(posedge core_clk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(posedge core_clk);
            if (arready === 1'h1) begin
                arvalid <= 1'h0;
            end
        end while (rvalid !== 1'h1);
        chk(rdata, {24'h0, e});
        chk({30'h0, rresp}, {30'h0, er});
        rready <= 1'h0;
    endtask : rc

    // Raises one reset request for three cycles, then checks resets seen and flags
    task automatic ev(input int k, input logic [7:0] f, input int nExp);
        int n0;
        n0 = nRst;
        @(posedge core_clk);
        case (k)
            0: rstPinN <= 1'h0;
            1: supplyTrip <= 1'h1;
            2: clkLossReq <= 1'h1;
            3: wdtReq <= 1'h1;
            default: cmp0Out <= 1'h0;
        endcase
        repeat (3) @(posedge core_clk);
        rstPinN <= 1'h1;
        supplyTrip <= 1'h0;
        clkLossReq <= 1'h0;
        wdtReq <= 1'h0;
        cmp0Out <= 1'h1;
        repeat (20) @(posedge core_clk);
        chk(32'(nRst - n0), 32'(nExp));
        rc(OFF_FLAGS, f, RESP_OKAY);
    endtask : ev

    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_sim

    initial begin
        repeat (20000) @(posedge core_clk);
        fail_count++;
        $display("BAD %0t watchdog expired", $time);
        end_sim();
    end

    initial begin
        repeat (12) @(posedge core_clk);
        srst <= 1'h0;
        rc(OFF_FLAGS, 8'h02, RESP_OKAY);
        rc(OFF_ENAB, 8'h00, RESP_OKAY);
        chk({31'h0, clkLossEnable}, 32'h0);
        $display("test power-on state done");
        // Bit 7 and the watchdog bit must not stick as enables
        wr(OFF_FLAGS, 8'hAE, RESP_OKAY);
        rc(OFF_ENAB, 8'h26, RESP_OKAY);
        chk({31'h0, clkLossEnable}, 32'h1);
        rc(OFF_FLAGS, 8'h02, RESP_OKAY);
        chk(32'(nRst), 32'h0);
        wr(5'h10, 8'h01, RESP_SLVERR);
        rc(5'h1C, 8'h00, RESP_SLVERR);
        $display("test enables done");
        wr(OFF_FLAGS, 8'h36, RESP_OKAY);
        repeat (5) @(posedge core_clk);
        chk(32'(nRst), 32'h1);
        rc(OFF_FLAGS, 8'h10, RESP_OKAY);
        rc(OFF_ENAB, 8'h26, RESP_OKAY);
        $display("test software reset done");
        ev(2, 8'h04, 1);
        ev(3, 8'h08, 1);
        wr(OFF_FLAGS, 8'h2E, RESP_OKAY);
        rc(OFF_FLAGS, 8'h08, RESP_OKAY);
        ev(4, 8'h20, 1);
        ev(0, 8'h01, 1);
        ev(1, 8'h02, 1);
        // Comparator disarmed: a low output must not reset
        wr(OFF_FLAGS, 8'h06, RESP_OKAY);
        ev(4, 8'h02, 0);
        wr(OFF_FLAGS, 8'h80, RESP_OKAY);
        rc(OFF_ENAB, 8'h00, RESP_OKAY);
        chk({31'h0, clkLossEnable}, 32'h0);
        $display("test reset causes done");
        rc(OFF_STAT, 8'h3F, RESP_OKAY);
        chk({31'h0, irq}, 32'h0);
        wr(OFF_MASK, 8'h01, RESP_OKAY);
        chk({31'h0, irq}, 32'h1);
        wr(OFF_STAT, 8'h01, RESP_OKAY);
        chk({31'h0, irq}, 32'h0);
        rc(OFF_STAT, 8'h3E, RESP_OKAY);
        rc(OFF_MASK, 8'h01, RESP_OKAY);
        ev(0, 8'h01, 1);
        chk({31'h0, irq}, 32'h1);
        $display("test interrupt done");
        end_sim();
    end
endmodule : rcf_reset_cause_flags_test
